// *** common/irq_router_pkg.sv ***
package irq_router_pkg;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_SOURCE    = 8'h0C;
  localparam logic [7:0] ADDR_WAKE_CFG  = 8'h2C;
  localparam logic [7:0] ADDR_IRQ_EN    = 8'h2D;
  localparam logic [7:0] ADDR_IRQ_ROUTE = 8'h2E;

  // ------------------------------------------------------------
  // Reset and read values
  // ------------------------------------------------------------
  localparam logic [7:0] RESET_VALUE   = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  localparam logic [7:0] NO_BITS       = 8'h00;

  // ------------------------------------------------------------
  // Source bit positions (enable, routing and status share them)
  // ------------------------------------------------------------
  localparam int SRC_SLEEP_WAKE   = 7;
  localparam int SRC_TRANSIENT    = 5;
  localparam int SRC_ORIENT       = 4;
  localparam int SRC_PULSE        = 3;
  localparam int SRC_FALL_MOTION  = 2;
  localparam int SRC_SAMPLE_READY = 0;
  localparam logic [7:0] SRC_MASK = 8'hBD;

  // ------------------------------------------------------------
  // Wake and pin configuration bit positions
  // ------------------------------------------------------------
  localparam int WAKE_TRANSIENT   = 6;
  localparam int WAKE_ORIENT      = 5;
  localparam int WAKE_PULSE       = 4;
  localparam int WAKE_FALL_MOTION = 3;
  localparam int CFG_POLARITY     = 1;
  localparam int CFG_OUTPUT_TYPE  = 0;
  localparam logic [7:0] WAKE_CFG_MASK = 8'h7B;

endpackage : irq_router_pkg

// *** logic/irq_pin_driver.sv ***
module irq_pin_driver
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Request and configuration
  input  wire logic assert_req,
  input  wire logic polarity,
  input  wire logic open_drain,
  // Pin
  output logic      pin_out,
  output logic      pin_oe
);

  typedef struct packed {
    logic out;
    logic oe;
  } pin_state_t;

  pin_state_t q;
  pin_state_t d;

  // ------------------------------------------------------------
  // Pin level and drive
  // ------------------------------------------------------------
  always_comb
  begin
    d     = q;
    d.out = assert_req ? polarity : !polarity;     // see R05
    // Open drain only pulls to the active level
    d.oe  = open_drain ? assert_req : 1'b1;        // see R06 see R18
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      // Idle push-pull, active low: drive high
      q <= '{out: 1'b1, oe: 1'b1};
    end
    else
    begin
      q <= d;
    end
  end

  assign pin_out = q.out;
  assign pin_oe  = q.oe;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_pin_level_pol: assert property (                       // see R05
    @(posedge clk) disable iff (rst)
    pin_oe |-> pin_out == ($past(assert_req) ? $past(polarity)
                                              : !$past(polarity)))
  else $error("pin level does not follow polarity");

  a_od_release: assert property (                          // see R18
    @(posedge clk) disable iff (rst)
    (open_drain && !assert_req) |=> !pin_oe)
  else $error("open drain pin driven while idle");

  a_pp_driven: assert property (                           // see R06
    @(posedge clk) disable iff (rst)
    !open_drain |=> pin_oe)
  else $error("push-pull pin released");

endmodule : irq_pin_driver

// *** logic/sensor_interrupt_router.sv ***
// Summary of operation
// R01 - Transient wake bit lets transient wake sleep
// R02 - Orientation wake bit lets orientation wake sleep
// R03 - Pulse wake bit lets pulse wake sleep
// R04 - Fall/motion wake bit lets it wake sleep
// R05 - Polarity bit: zero active low, one high
// R06 - Output type: zero push-pull, one open drain
// R07 - Enable bit 7 gates auto-sleep/wake events
// R08 - Enable bit 5 gates transient events
// R09 - Enable bit 4 gates orientation events
// R10 - Enable bit 3 gates pulse events
// R11 - Enable bit 2 gates fall/motion events
// R12 - Enable bit 0 gates data-ready events
// R13 - Only enabled sources reach either pin
// R14 - Route bit zero to pin two, one to one
// R15 - Host reads source register to find causes
// R16 - Wake/pin config bits 6,5,4,3,1,0 layout
// R17 - Pin asserted while any routed flag active
// R18 - Open drain drives active only; unused bits zero
module sensor_interrupt_router
(
  // Clock and reset
  input  wire logic       CLOCK,
  input  wire logic       SYS_RST,
  // Internal register port
  input  wire logic [7:0] REG_ADDR,
  input  wire logic       REG_WR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_RD,
  output logic      [7:0] REG_RDATA,
  // Detector event flags and power state
  input  wire logic       EVT_SLEEP_WAKE,
  input  wire logic       EVT_TRANSIENT,
  input  wire logic       EVT_ORIENT,
  input  wire logic       EVT_PULSE,
  input  wire logic       EVT_FALL_MOTION,
  input  wire logic       EVT_SAMPLE_READY,
  input  wire logic       SLEEP_MODE,
  // Wake request to the power controller
  output logic            WAKE_REQ,
  // Interrupt pins
  output logic            IRQ_PIN_ONE_OUT,
  output logic            IRQ_PIN_ONE_OE,
  output logic            IRQ_PIN_TWO_OUT,
  output logic            IRQ_PIN_TWO_OE
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] wake_cfg;
    logic [7:0] irq_en;
    logic [7:0] irq_route;
    logic [7:0] rdata;
    logic       wake;
  } core_state_t;

  core_state_t q;
  core_state_t d;

  logic [7:0] evt_vec;
  logic [7:0] evt_live;
  logic [7:0] gated;
  logic [7:0] wake_sel;
  logic       req_one;
  logic       req_two;
  logic       polarity;
  logic       open_drain;

  assign polarity   = q.wake_cfg[irq_router_pkg::CFG_POLARITY];
  assign open_drain = q.wake_cfg[irq_router_pkg::CFG_OUTPUT_TYPE];

  // ------------------------------------------------------------
  // Event gating and routing
  // ------------------------------------------------------------
  always_comb
  begin
    evt_vec = irq_router_pkg::NO_BITS;
    evt_vec[irq_router_pkg::SRC_SLEEP_WAKE]   = EVT_SLEEP_WAKE;
    evt_vec[irq_router_pkg::SRC_TRANSIENT]    = EVT_TRANSIENT;
    evt_vec[irq_router_pkg::SRC_ORIENT]       = EVT_ORIENT;
    evt_vec[irq_router_pkg::SRC_PULSE]        = EVT_PULSE;
    evt_vec[irq_router_pkg::SRC_FALL_MOTION]  = EVT_FALL_MOTION;
    evt_vec[irq_router_pkg::SRC_SAMPLE_READY] = EVT_SAMPLE_READY;

    // Transient, orientation, pulse and fall/motion detectors not allowed to wake are bypassed while asleep
    wake_sel = irq_router_pkg::NO_BITS;
    wake_sel[irq_router_pkg::SRC_TRANSIENT] =
      q.wake_cfg[irq_router_pkg::WAKE_TRANSIENT];        // see R01
    wake_sel[irq_router_pkg::SRC_ORIENT] =
      q.wake_cfg[irq_router_pkg::WAKE_ORIENT];           // see R02
    wake_sel[irq_router_pkg::SRC_PULSE] =
      q.wake_cfg[irq_router_pkg::WAKE_PULSE];            // see R03
    wake_sel[irq_router_pkg::SRC_FALL_MOTION] =
      q.wake_cfg[irq_router_pkg::WAKE_FALL_MOTION];      // see R04

    evt_live = evt_vec;
    if (SLEEP_MODE)
    begin
      evt_live[irq_router_pkg::SRC_TRANSIENT] =
        evt_vec[irq_router_pkg::SRC_TRANSIENT] &
        wake_sel[irq_router_pkg::SRC_TRANSIENT];         // see R01
      evt_live[irq_router_pkg::SRC_ORIENT] =
        evt_vec[irq_router_pkg::SRC_ORIENT] &
        wake_sel[irq_router_pkg::SRC_ORIENT];            // see R02
      evt_live[irq_router_pkg::SRC_PULSE] =
        evt_vec[irq_router_pkg::SRC_PULSE] &
        wake_sel[irq_router_pkg::SRC_PULSE];             // see R03
      evt_live[irq_router_pkg::SRC_FALL_MOTION] =
        evt_vec[irq_router_pkg::SRC_FALL_MOTION] &
        wake_sel[irq_router_pkg::SRC_FALL_MOTION];       // see R04
    end

    // Each flag passes only through its own enable bit
    gated   = evt_live & q.irq_en;         // see R07 see R08 see R09
                                           // see R10 see R11 see R12
                                           // see R13
    req_one = |(gated & q.irq_route);      // see R14 see R17
    req_two = |(gated & ~q.irq_route);     // see R14 see R17
  end

  // ------------------------------------------------------------
  // Register port and wake request
  // ------------------------------------------------------------
  always_comb
  begin
    d = q;
    if (REG_WR)
    begin
      case (REG_ADDR)
        irq_router_pkg::ADDR_WAKE_CFG:
          d.wake_cfg = REG_WDATA &
                       irq_router_pkg::WAKE_CFG_MASK;    // see R16
        irq_router_pkg::ADDR_IRQ_EN:
          d.irq_en = REG_WDATA & irq_router_pkg::SRC_MASK; // see R18
        irq_router_pkg::ADDR_IRQ_ROUTE:
          d.irq_route = REG_WDATA &
                        irq_router_pkg::SRC_MASK;        // see R18
        default:
          d.irq_en = q.irq_en;
      endcase
    end
    // A read in the same cycle as a write returns the old value
    if (REG_RD)
    begin
      case (REG_ADDR)
        irq_router_pkg::ADDR_SOURCE:
          d.rdata = gated;                               // see R15
        irq_router_pkg::ADDR_WAKE_CFG:
          d.rdata = q.wake_cfg;
        irq_router_pkg::ADDR_IRQ_EN:
          d.rdata = q.irq_en;
        irq_router_pkg::ADDR_IRQ_ROUTE:
          d.rdata = q.irq_route;
        default:
          d.rdata = irq_router_pkg::READ_UNMAPPED;
      endcase
    end
    // Only wake-enabled detectors raise the wake request while asleep
    d.wake = SLEEP_MODE && |(gated & wake_sel);  // see R01 see R02
                                                 // see R03 see R04
  end

  always_ff @(posedge CLOCK)
  begin
    if (SYS_RST)
    begin
      q <= '{wake_cfg:  irq_router_pkg::RESET_VALUE,
             irq_en:    irq_router_pkg::RESET_VALUE,
             irq_route: irq_router_pkg::RESET_VALUE,
             rdata:     irq_router_pkg::RESET_VALUE,
             wake:      1'b0};
    end
    else
    begin
      q <= d;
    end
  end

  assign REG_RDATA = q.rdata;
  assign WAKE_REQ  = q.wake;

  // ------------------------------------------------------------
  // Pin drivers
  // ------------------------------------------------------------
  irq_pin_driver u_pin_one
  (
    .clk        (CLOCK),
    .rst        (SYS_RST),
    .assert_req (req_one),
    .polarity   (polarity),
    .open_drain (open_drain),
    .pin_out    (IRQ_PIN_ONE_OUT),
    .pin_oe     (IRQ_PIN_ONE_OE)
  );

  irq_pin_driver u_pin_two
  (
    .clk        (CLOCK),
    .rst        (SYS_RST),
    .assert_req (req_two),
    .polarity   (polarity),
    .open_drain (open_drain),
    .pin_out    (IRQ_PIN_TWO_OUT),
    .pin_oe     (IRQ_PIN_TWO_OE)
  );

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_sleep_trans_bypass: assert property (                   // see R01
    @(posedge CLOCK) disable iff (SYS_RST)
    (SLEEP_MODE && !q.wake_cfg[irq_router_pkg::WAKE_TRANSIENT])
      |-> !gated[irq_router_pkg::SRC_TRANSIENT])
  else $error("transient passed while bypassed in sleep");

  a_sleep_orient_wake: assert property (                    // see R02
    @(posedge CLOCK) disable iff (SYS_RST)
    (SLEEP_MODE && EVT_ORIENT
      && q.wake_cfg[irq_router_pkg::WAKE_ORIENT]
      && q.irq_en[irq_router_pkg::SRC_ORIENT]) |=> WAKE_REQ)
  else $error("orientation event did not wake");

  a_sleep_pulse_quiet: assert property (                    // see R03
    @(posedge CLOCK) disable iff (SYS_RST)
    (SLEEP_MODE && !q.wake_cfg[irq_router_pkg::WAKE_PULSE]
      && (evt_vec & ~(8'h01 << irq_router_pkg::SRC_PULSE)) == 8'h00)
      |=> !WAKE_REQ)
  else $error("bypassed pulse raised wake");

  a_sleep_fall_wake: assert property (                      // see R04
    @(posedge CLOCK) disable iff (SYS_RST)
    (SLEEP_MODE && EVT_FALL_MOTION
      && q.wake_cfg[irq_router_pkg::WAKE_FALL_MOTION]
      && q.irq_en[irq_router_pkg::SRC_FALL_MOTION]) |=> WAKE_REQ)
  else $error("fall/motion event did not wake");

  a_awake_no_wake: assert property (                        // see R01
    @(posedge CLOCK) disable iff (SYS_RST)
    !SLEEP_MODE |=> !WAKE_REQ)
  else $error("wake request while awake");

  a_disabled_silent: assert property (                      // see R13
    @(posedge CLOCK) disable iff (SYS_RST)
    (q.irq_en == 8'h00) |-> (!req_one && !req_two))
  else $error("pin request with all sources disabled");

  a_sleep_wake_gate: assert property (                      // see R07
    @(posedge CLOCK) disable iff (SYS_RST)
    !q.irq_en[irq_router_pkg::SRC_SLEEP_WAKE]
      |-> !gated[irq_router_pkg::SRC_SLEEP_WAKE])
  else $error("auto-sleep event passed while disabled");

  a_ready_route: assert property (                  // see R12 see R14
    @(posedge CLOCK) disable iff (SYS_RST)
    (EVT_SAMPLE_READY && q.irq_en[irq_router_pkg::SRC_SAMPLE_READY]
      && !q.irq_route[irq_router_pkg::SRC_SAMPLE_READY]) |-> req_two)
  else $error("data-ready not routed to pin two");

  a_pin_one_active: assert property (               // see R17 see R05
    @(posedge CLOCK) disable iff (SYS_RST)
    req_one |=> IRQ_PIN_ONE_OUT == $past(polarity))
  else $error("pin one not at active level");

  a_pin_two_idle: assert property (                 // see R17 see R18
    @(posedge CLOCK) disable iff (SYS_RST)
    !req_two |=> (!IRQ_PIN_TWO_OE
                  || IRQ_PIN_TWO_OUT == !$past(polarity)))
  else $error("pin two not released when idle");

  a_enable_write: assert property (                 // see R18 see R08
    @(posedge CLOCK) disable iff (SYS_RST)
    (REG_WR && REG_ADDR == irq_router_pkg::ADDR_IRQ_EN)
      |=> q.irq_en == ($past(REG_WDATA) & irq_router_pkg::SRC_MASK))
  else $error("enable register write lost");

  a_cfg_layout: assert property (                           // see R16
    @(posedge CLOCK) disable iff (SYS_RST)
    (REG_WR && REG_ADDR == irq_router_pkg::ADDR_WAKE_CFG)
      |=> (polarity ==
             $past(REG_WDATA[irq_router_pkg::CFG_POLARITY])
           && open_drain ==
             $past(REG_WDATA[irq_router_pkg::CFG_OUTPUT_TYPE])
           && (q.wake_cfg & ~irq_router_pkg::WAKE_CFG_MASK) == 8'h00))
  else $error("wake/pin config layout wrong");

  a_source_read: assert property (                          // see R15
    @(posedge CLOCK) disable iff (SYS_RST)
    (REG_RD && REG_ADDR == irq_router_pkg::ADDR_SOURCE)
      |=> REG_RDATA == $past(gated))
  else $error("source register read mismatch");

endmodule : sensor_interrupt_router

// *** test/irq_host_model.sv ***
module irq_host_model
(
  // Pin one as the device drives it
  input  wire logic one_out,
  input  wire logic one_oe,
  // Pin two as the device drives it
  input  wire logic two_out,
  input  wire logic two_oe,
  // Levels seen by the host
  output logic      one_wire,
  output logic      two_wire
);
  timeunit 1ns;
  timeprecision 1ns;

  // ------------------------------------------------------------
  // Wire resolution
  // ------------------------------------------------------------
  // Board pull-up: a released line goes high, never keeps the last value
  assign one_wire = one_oe ? one_out : 1'b1;
  assign two_wire = two_oe ? two_out : 1'b1;

endmodule : irq_host_model

// *** test/sensor_interrupt_router_bench.sv ***
module sensor_interrupt_router_bench;
  timeunit 1ns;
  timeprecision 1ns;

  // ------------------------------------------------------------
  // Row of the case table
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] en;
    logic [7:0] route;
    logic [7:0] cfg;
    logic [7:0] evt;
    logic       sleep;
    logic [7:0] st;
    logic [3:0] p;
    logic       wake;
  } row_t;

  logic       clock;
  logic       sys_rst;
  logic [7:0] reg_addr;
  logic       reg_wr;
  logic [7:0] reg_wdata;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic [7:0] evt;
  logic       sleep_mode;
  logic       wake_req;
  logic       one_out, one_oe, two_out, two_oe;
  logic       one_wire, two_wire;
  logic [7:0] d;
  logic [7:0] pins;
  int         n_mismatch;
  int         checked;
  int         cycles;
  row_t       rows [0:19];

  // Pins packed as wire one, enable one, wire two, enable two
  assign pins = {4'h0, one_wire, one_oe, two_wire, two_oe};

  sensor_interrupt_router sensor_interrupt_router_i
  (
    .CLOCK            (clock),
    .SYS_RST          (sys_rst),
    .REG_ADDR         (reg_addr),
    .REG_WR           (reg_wr),
    .REG_WDATA        (reg_wdata),
    .REG_RD           (reg_rd),
    .REG_RDATA        (reg_rdata),
    .EVT_SLEEP_WAKE   (evt[7]),
    .EVT_TRANSIENT    (evt[5]),
    .EVT_ORIENT       (evt[4]),
    .EVT_PULSE        (evt[3]),
    .EVT_FALL_MOTION  (evt[2]),
    .EVT_SAMPLE_READY (evt[0]),
    .SLEEP_MODE       (sleep_mode),
    .WAKE_REQ         (wake_req),
    .IRQ_PIN_ONE_OUT  (one_out),
    .IRQ_PIN_ONE_OE   (one_oe),
    .IRQ_PIN_TWO_OUT  (two_out),
    .IRQ_PIN_TWO_OE   (two_oe)
  );

  irq_host_model irq_host_model_i
  (
    .one_out  (one_out),
    .one_oe   (one_oe),
    .two_out  (two_out),
    .two_oe   (two_oe),
    .one_wire (one_wire),
    .two_wire (two_wire)
  );

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd

  task rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk(v, exp);
  endtask : rd_chk

  task reset_state;
    rd_chk(8'h2C, 8'h00);
    rd_chk(8'h2D, 8'h00);
    rd_chk(8'h2E, 8'h00);
    rd_chk(8'h0C, 8'h00);
    chk(pins, 8'h0F);
    chk({7'h00, wake_req}, 8'h00);
  endtask : reset_state

  task give_verdict;
    if (n_mismatch == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  // ------------------------------------------------------------
  // Clock and hang guard
  // ------------------------------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // A full run needs well under a thousand cycles
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      n_mismatch++;
      give_verdict();
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    n_mismatch = 0;
    checked    = 0;
    cycles     = 0;
    sys_rst    = 1'b1;
    reg_addr   = 8'h00;
    reg_wr     = 1'b0;
    reg_wdata  = 8'h00;
    reg_rd     = 1'b0;
    evt        = 8'h00;
    sleep_mode = 1'b0;
    rows = '{
      {8'h00, 8'h00, 8'h00, 8'hBD, 1'b0, 8'h00, 4'hF, 1'b0},
      {8'h80, 8'h80, 8'h00, 8'h80, 1'b0, 8'h80, 4'h7, 1'b0},
      {8'h20, 8'h00, 8'h00, 8'h20, 1'b0, 8'h20, 4'hD, 1'b0},
      {8'h10, 8'h10, 8'h00, 8'h10, 1'b0, 8'h10, 4'h7, 1'b0},
      {8'h08, 8'h00, 8'h00, 8'h08, 1'b0, 8'h08, 4'hD, 1'b0},
      {8'h04, 8'h04, 8'h00, 8'h04, 1'b0, 8'h04, 4'h7, 1'b0},
      {8'h01, 8'h00, 8'h00, 8'h01, 1'b0, 8'h01, 4'hD, 1'b0},
      {8'h3C, 8'hFF, 8'h00, 8'h81, 1'b0, 8'h00, 4'hF, 1'b0},
      {8'hBD, 8'h20, 8'h00, 8'h21, 1'b0, 8'h21, 4'h5, 1'b0},
      {8'h3C, 8'h00, 8'h00, 8'h3C, 1'b1, 8'h00, 4'hF, 1'b0},
      {8'h3C, 8'h00, 8'h40, 8'h3C, 1'b1, 8'h20, 4'hD, 1'b1},
      {8'h3C, 8'h00, 8'h20, 8'h3C, 1'b1, 8'h10, 4'hD, 1'b1},
      {8'h3C, 8'h00, 8'h10, 8'h3C, 1'b1, 8'h08, 4'hD, 1'b1},
      {8'h08, 8'h00, 8'h00, 8'h08, 1'b1, 8'h00, 4'hF, 1'b0},
      {8'h3C, 8'h00, 8'h08, 8'h3C, 1'b1, 8'h04, 4'hD, 1'b1},
      {8'h81, 8'h00, 8'h78, 8'h81, 1'b1, 8'h81, 4'hD, 1'b0},
      {8'h00, 8'h00, 8'h78, 8'h3C, 1'b1, 8'h00, 4'hF, 1'b0},
      {8'h08, 8'h08, 8'h02, 8'h08, 1'b0, 8'h08, 4'hD, 1'b0},
      {8'h08, 8'h08, 8'h01, 8'h08, 1'b0, 8'h08, 4'h6, 1'b0},
      {8'h08, 8'h08, 8'h03, 8'h08, 1'b0, 8'h08, 4'hE, 1'b0}
    };
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    reset_state();
    foreach (rows[i])
    begin
      wr(8'h2D, rows[i].en);
      wr(8'h2E, rows[i].route);
      wr(8'h2C, rows[i].cfg);
      @(posedge clock);
      evt        <= rows[i].evt;
      sleep_mode <= rows[i].sleep;
      repeat (2) @(posedge clock);
      #1;
      chk(pins, {4'h0, rows[i].p});
      chk({7'h00, wake_req}, {7'h00, rows[i].wake});
      rd(8'h0C, d);
      chk(d, rows[i].st);
    end
    // Unused bits, read-only status and an unmapped place
    @(posedge clock);
    evt        <= 8'h21;
    sleep_mode <= 1'b0;
    wr(8'h2D, 8'hFF);
    rd_chk(8'h2D, 8'hBD);
    wr(8'h2E, 8'hFF);
    rd_chk(8'h2E, 8'hBD);
    wr(8'h2C, 8'hFF);
    rd_chk(8'h2C, 8'h7B);
    // Status stays live flags whatever is written to it
    wr(8'h0C, 8'h00);
    rd_chk(8'h0C, 8'h21);
    wr(8'h2F, 8'hFF);
    rd_chk(8'h2F, 8'h00);
    rd_chk(8'h2D, 8'hBD);
    // Read and write of one place in one cycle return the old value
    @(posedge clock);
    reg_addr  <= 8'h2E;
    reg_wdata <= 8'h00;
    reg_wr    <= 1'b1;
    reg_rd    <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, 8'hBD);
    rd_chk(8'h2E, 8'h00);
    // Second reset with every source flagging
    @(posedge clock);
    evt     <= 8'hBD;
    sys_rst <= 1'b1;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    reset_state();
    give_verdict();
  end

endmodule : sensor_interrupt_router_bench
